// ===== inc/pau_pkg.sv
// Package with register map, field layout, encodings and timing figures of the alarm unit.
package pau_pkg;

	// Number of alarm channels and data width of measured values.
	localparam int PAU_NUM_ALARMS = 3;
	localparam int PAU_VALUE_W = 16;

	// Register byte offsets; each alarm owns a block of four words.
	localparam logic [11:0] PAU_CTRL_OFS = 12'h000;
	localparam logic [11:0] PAU_STATUS_OFS = 12'h004;
	localparam logic [11:0] PAU_ALARM_BASE = 12'h010;
	localparam logic [11:0] PAU_ALARM_STRIDE = 12'h010;
	localparam logic [11:0] PAU_CFG_OFS = 12'h000;
	localparam logic [11:0] PAU_THR_OFS = 12'h004;
	localparam logic [11:0] PAU_HYS_OFS = 12'h008;
	localparam logic [11:0] PAU_FILT_OFS = 12'h00C;

	// Control register fields.
	localparam int PAU_CTRL_CONFIG_BIT = 0;
	localparam int PAU_CTRL_RESTORE_BIT = 1;

	// Status register fields.
	localparam int PAU_STAT_ALARM_LSB = 0;
	localparam int PAU_STAT_MASK_LSB = 3;
	localparam int PAU_STAT_RELAY_LSB = 6;
	localparam int PAU_STAT_ACK_BIT = 9;

	// Alarm source select.
	typedef enum logic [1:0] {
		PAU_SRC_OFF = 2'h0,
		PAU_SRC_PRIMARY = 2'h1,
		PAU_SRC_SECONDARY = 2'h2
	} pau_source_type;

	// Alarm type select.
	typedef enum logic [1:0] {
		PAU_TYPE_HIGH = 2'h0,
		PAU_TYPE_LOW = 2'h1,
		PAU_TYPE_LOW_MASKED = 2'h2
	} pau_kind_type;

	// Per-alarm configuration word, packed as it sits in the register.
	typedef struct packed {
		logic [2:0] filter_time;
		logic relay_polarity;
		logic reset_mode;
		logic [1:0] type_select;
		logic [1:0] source_select;
	} pau_cfg_type;

	// Reset value: source off, high, auto, failsafe (0), filter 0.4 s (code 1).
	localparam pau_cfg_type PAU_CFG_RESET = 9'h040;
	localparam logic PAU_RESET_LATCHING = 1'b1;
	localparam logic PAU_POL_NONFAILSAFE = 1'b1;

	// Filter time constants in milliseconds for codes 0..6; 0 means off.
	localparam int PAU_FILT_MS [7] = '{0, 400, 1000, 2000, 3000, 4000, 5000};

	// Threshold ceiling and hysteresis bounds in tenths of a percent of span.
	localparam int PAU_THR_MAX_PERMIL = 1100;
	localparam int PAU_HYS_MIN_PERMIL = 1;
	localparam int PAU_HYS_MAX_PERMIL = 100;
	localparam int PAU_HYS_DEF_PERMIL = 10;

endpackage : pau_pkg

// ===== verilog/pau_alarm_unit.sv
// Three-channel process alarm unit with APB register access.
//
// Contract
// - High alarm sets above threshold.
// - High alarm clears below threshold minus hysteresis.
// - Low alarm sets below threshold.
// - Low alarm clears above threshold plus hysteresis.
// - Start-up mask blocks alarm until safe side.
// - Unmasked alarm triggers on every crossing.
// - Mask restore command re-arms start-up masks.
// - Auto reset follows condition, no acknowledge.
// - Latching holds until cleared and acknowledged.
// - Acknowledge during condition is ignored.
// - Failsafe: coil energised when no alarm.
// - Non-failsafe: coil energised only in alarm.
// - Reset selects failsafe polarity everywhere.
// - Threshold limited to 110 percent span.
// - Hysteresis 0.1 to 10 percent, min 1.
// - Filter off, 0.4, 1, 2, 3, 4, 5 s.
// - No alarm state survives a reset.
// - Configuration mode gives no alarm indication.
// - Source: disabled, primary or secondary input.
// - Type: high, low or masked low.
module pau_alarm_unit import pau_pkg::*; #(
	parameter int SPAN = 3000,
	parameter int SAMPLE_MS = 100
) (
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// APB slave.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Measurement path.
	input wire logic sample_valid,
	input wire logic [PAU_VALUE_W-1:0] primary_value,
	input wire logic [PAU_VALUE_W-1:0] secondary_value,
	// Acknowledge contact pin, low when closed.
	input wire logic ack_contact_n,
	// Alarm indication and relay coil drives.
	output logic [PAU_NUM_ALARMS-1:0] alarm_active,
	output logic [PAU_NUM_ALARMS-1:0] relay_drive
);
	////////////////////////////////////////////////////////////////////////////
	// Limits derived from the span.
	// Highest accepted threshold.
	localparam logic [PAU_VALUE_W-1:0] THR_MAX = PAU_VALUE_W'(SPAN * PAU_THR_MAX_PERMIL / 1000);
	// Hysteresis bounds, the lower one never below one digit.
	localparam int HYS_MIN_RAW = SPAN * PAU_HYS_MIN_PERMIL / 1000;
	localparam logic [PAU_VALUE_W-1:0] HYS_MIN = PAU_VALUE_W'(HYS_MIN_RAW < 1 ? 1 : HYS_MIN_RAW);
	localparam logic [PAU_VALUE_W-1:0] HYS_MAX = PAU_VALUE_W'(SPAN * PAU_HYS_MAX_PERMIL / 1000);
	localparam logic [PAU_VALUE_W-1:0] HYS_DEF = PAU_VALUE_W'(SPAN * PAU_HYS_DEF_PERMIL / 1000);
	////////////////////////////////////////////////////////////////////////////
	// Functions.
	// Filter shift for a time code: tau in samples, rounded to a power of two.
	function automatic logic [3:0] filt_shift(input logic [2:0] code);
		int tau;
		tau = (code > 3'h6) ? 0 : PAU_FILT_MS[code] / SAMPLE_MS;
		filt_shift = (tau <= 1) ? 4'h0 : 4'($clog2(tau));
	endfunction : filt_shift
	// Clamp a written value into the range lo..hi.
	function automatic logic [PAU_VALUE_W-1:0] clamp(input logic [PAU_VALUE_W-1:0] v,
		input logic [PAU_VALUE_W-1:0] lo, input logic [PAU_VALUE_W-1:0] hi);
		clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
	endfunction : clamp
	////////////////////////////////////////////////////////////////////////////
	// Acknowledge contact synchroniser.
	// Two flip-flops; only the second one is looked at.
	logic ack_meta_reg;
	logic ack_sync_reg;
	// The contact is active low; the synchronised level is active high.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ack_meta_reg <= 1'b0;
			ack_sync_reg <= 1'b0;
		end else begin
			ack_meta_reg <= ~ack_contact_n;
			ack_sync_reg <= ack_meta_reg;
		end
	end
	////////////////////////////////////////////////////////////////////////////
	// APB register file.
	// Control and per-alarm settings.
	logic config_mode_reg;
	logic mask_restore_command;
	pau_cfg_type cfg_reg [PAU_NUM_ALARMS];
	logic [PAU_VALUE_W-1:0] thr_reg [PAU_NUM_ALARMS];
	logic [PAU_VALUE_W-1:0] hys_reg [PAU_NUM_ALARMS];
	// Filtered values, alarm flags, conditions and masks per alarm.
	logic [PAU_VALUE_W-1:0] filt_reg [PAU_NUM_ALARMS];
	logic [PAU_NUM_ALARMS-1:0] cond_reg;
	logic [PAU_NUM_ALARMS-1:0] alarm_reg;
	logic [PAU_NUM_ALARMS-1:0] mask_reg;
	logic [PAU_NUM_ALARMS-1:0] relay_reg;
	// One-cycle strobe: filtered values are fresh and must be evaluated.
	logic eval_reg;
	// Bus decode.
	logic wr_en;
	logic [1:0] sel_alarm;
	logic in_alarm;
	logic mapped;
	logic [31:0] rd_next;
	// Every transfer completes in its first access cycle.
	assign pready = 1'b1;
	assign wr_en = psel && penable && pwrite && mapped;
	assign sel_alarm = 2'((paddr - PAU_ALARM_BASE) / PAU_ALARM_STRIDE);
	// The full-width block index keeps higher blocks from aliasing onto real ones.
	assign in_alarm = (paddr >= PAU_ALARM_BASE)
		&& (((paddr - PAU_ALARM_BASE) / PAU_ALARM_STRIDE) < 12'(PAU_NUM_ALARMS));
	// Read decode; unmapped addresses read zero and flag an error.
	always_comb begin
		rd_next = 32'h0000_0000;
		mapped = 1'b1;
		if (paddr[1:0] != 2'h0) begin
			mapped = 1'b0;
		end else if (paddr == PAU_CTRL_OFS) begin
			rd_next[PAU_CTRL_CONFIG_BIT] = config_mode_reg;
		end else if (paddr == PAU_STATUS_OFS) begin
			rd_next[PAU_STAT_ALARM_LSB +: PAU_NUM_ALARMS] = alarm_active;
			rd_next[PAU_STAT_MASK_LSB +: PAU_NUM_ALARMS] = mask_reg;
			rd_next[PAU_STAT_RELAY_LSB +: PAU_NUM_ALARMS] = relay_reg;
			rd_next[PAU_STAT_ACK_BIT] = ack_sync_reg;
		end else if (in_alarm) begin
			unique case (paddr[3:0])
				PAU_CFG_OFS[3:0]: rd_next[8:0] = cfg_reg[sel_alarm];
				PAU_THR_OFS[3:0]: rd_next[PAU_VALUE_W-1:0] = thr_reg[sel_alarm];
				PAU_HYS_OFS[3:0]: rd_next[PAU_VALUE_W-1:0] = hys_reg[sel_alarm];
				PAU_FILT_OFS[3:0]: rd_next[PAU_VALUE_W-1:0] = filt_reg[sel_alarm];
				default: mapped = 1'b0;
			endcase
		end else begin
			mapped = 1'b0;
		end
	end
	// Error answer for unmapped or misaligned addresses.
	assign pslverr = psel && penable && !mapped;
	// Read data is captured in the setup cycle and stands through the access.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			prdata <= rd_next;
		end
	end
	// Control register; the restore bit is a write pulse and reads back zero.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			config_mode_reg <= 1'b0;
			mask_restore_command <= 1'b0;
		end else begin
			mask_restore_command <= wr_en && (paddr == PAU_CTRL_OFS)
				&& pwdata[PAU_CTRL_RESTORE_BIT];
			if (wr_en && (paddr == PAU_CTRL_OFS)) begin
				config_mode_reg <= pwdata[PAU_CTRL_CONFIG_BIT];
			end
		end
	end
	// Per-alarm settings; threshold and hysteresis writes are clamped into their legal ranges.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < PAU_NUM_ALARMS; i++) begin
				cfg_reg[i] <= PAU_CFG_RESET;
				thr_reg[i] <= THR_MAX;
				hys_reg[i] <= HYS_DEF;
			end
		end else if (wr_en && in_alarm) begin
			unique case (paddr[3:0])
				PAU_CFG_OFS[3:0]: cfg_reg[sel_alarm] <= pwdata[8:0];
				PAU_THR_OFS[3:0]: thr_reg[sel_alarm] <= clamp(pwdata[PAU_VALUE_W-1:0],
					PAU_VALUE_W'(0), THR_MAX);
				PAU_HYS_OFS[3:0]: hys_reg[sel_alarm] <= clamp(pwdata[PAU_VALUE_W-1:0],
					HYS_MIN, HYS_MAX);
				default: ;
			endcase
		end
	end
	////////////////////////////////////////////////////////////////////////////
	// Input filters, one first-order low-pass per alarm.
	// Marks the cycle after a sample, when the filtered values are current.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			eval_reg <= 1'b0;
		end else begin
			eval_reg <= sample_valid;
		end
	end
	// Each filter steps once per sample towards its selected source.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < PAU_NUM_ALARMS; i++) begin
				filt_reg[i] <= '0;
			end
		end else if (sample_valid) begin
			for (int i = 0; i < PAU_NUM_ALARMS; i++) begin
				logic [PAU_VALUE_W-1:0] src;
				logic signed [PAU_VALUE_W+1:0] diff;
				src = (cfg_reg[i].source_select == PAU_SRC_SECONDARY) ?
					secondary_value : primary_value;
				diff = $signed({2'b00, src}) - $signed({2'b00, filt_reg[i]});
				if (filt_shift(cfg_reg[i].filter_time) == 4'h0) begin
					filt_reg[i] <= src;
				end else begin
					filt_reg[i] <= PAU_VALUE_W'($signed({2'b00, filt_reg[i]})
						+ (diff >>> filt_shift(cfg_reg[i].filter_time)));
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Alarm evaluation.
	// Threshold comparisons per alarm; the hysteresis sums are 17 bits wide so no side can wrap.
	logic [PAU_NUM_ALARMS-1:0] above_thr;
	logic [PAU_NUM_ALARMS-1:0] below_thr;
	logic [PAU_NUM_ALARMS-1:0] high_clear;
	logic [PAU_NUM_ALARMS-1:0] low_clear;
	logic [PAU_NUM_ALARMS-1:0] enabled;
	// Compares each filtered value with its threshold and hysteresis bands.
	always_comb begin
		for (int i = 0; i < PAU_NUM_ALARMS; i++) begin
			above_thr[i] = filt_reg[i] > thr_reg[i];
			below_thr[i] = filt_reg[i] < thr_reg[i];
			high_clear[i] = ({1'b0, filt_reg[i]} + {1'b0, hys_reg[i]}) < {1'b0, thr_reg[i]};
			low_clear[i] = {1'b0, filt_reg[i]} > ({1'b0, thr_reg[i]} + {1'b0, hys_reg[i]});
			enabled[i] = (cfg_reg[i].source_select == PAU_SRC_PRIMARY)
				|| (cfg_reg[i].source_select == PAU_SRC_SECONDARY);
		end
	end
	// Start-up masks: armed at reset and on restore, lifted on the safe side.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mask_reg <= '1;
		end else begin
			for (int i = 0; i < PAU_NUM_ALARMS; i++) begin
				if (mask_restore_command) begin
					mask_reg[i] <= 1'b1;
				end else if (eval_reg && above_thr[i]) begin
					mask_reg[i] <= 1'b0;
				end
			end
		end
	end
	// Hysteretic alarm condition, held inactive while disabled or in configuration mode, and for the masked low type while masked.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cond_reg <= '0;
		end else begin
			for (int i = 0; i < PAU_NUM_ALARMS; i++) begin
				if (!enabled[i] || config_mode_reg) begin
					cond_reg[i] <= 1'b0;
				end else if (eval_reg) begin
					unique case (cfg_reg[i].type_select)
						PAU_TYPE_HIGH: begin
							if (above_thr[i]) cond_reg[i] <= 1'b1;
							else if (high_clear[i]) cond_reg[i] <= 1'b0;
						end
						PAU_TYPE_LOW_MASKED: begin
							if (below_thr[i] && !mask_reg[i]) cond_reg[i] <= 1'b1;
							else if (low_clear[i] || mask_reg[i]) cond_reg[i] <= 1'b0;
						end
						default: begin
							if (below_thr[i]) cond_reg[i] <= 1'b1;
							else if (low_clear[i]) cond_reg[i] <= 1'b0;
						end
					endcase
				end
			end
		end
	end
	// Alarm flags: auto follows the condition, latching waits for acknowledge.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			alarm_reg <= '0;
		end else begin
			for (int i = 0; i < PAU_NUM_ALARMS; i++) begin
				if (!enabled[i] || config_mode_reg) begin
					alarm_reg[i] <= 1'b0;
				end else if (cond_reg[i]) begin
					alarm_reg[i] <= 1'b1;
				end else if (cfg_reg[i].reset_mode != PAU_RESET_LATCHING) begin
					alarm_reg[i] <= 1'b0;
				end else if (ack_sync_reg) begin
					alarm_reg[i] <= 1'b0;
				end
			end
		end
	end
	// Relay coil drives; no alarm is shown from the first edge after configuration mode is entered.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			relay_reg <= '1;
		end else begin
			for (int i = 0; i < PAU_NUM_ALARMS; i++) begin
				if (cfg_reg[i].relay_polarity == PAU_POL_NONFAILSAFE) begin
					relay_reg[i] <= alarm_next_shown(i);
				end else begin
					relay_reg[i] <= !alarm_next_shown(i);
				end
			end
		end
	end
	// The alarm as the relay should show it on the next edge.
	function automatic logic alarm_next_shown(input int idx);
		alarm_next_shown = alarm_reg[idx] && !config_mode_reg;
	endfunction : alarm_next_shown
	assign alarm_active = alarm_reg;
	assign relay_drive = relay_reg;
	////////////////////////////////////////////////////////////////////////////
	// Assertions and covers.
	for (genvar g = 0; g < PAU_NUM_ALARMS; g++) begin : g_chk
		high_set_a: assert property (@(posedge pclk) disable iff (!presetn)
			eval_reg && enabled[g] && !config_mode_reg
			&& cfg_reg[g].type_select == PAU_TYPE_HIGH && above_thr[g] |=> cond_reg[g])
			else $error("high alarm condition not set");
		high_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
			cond_reg[g] && enabled[g] && !config_mode_reg && !eval_reg |=> cond_reg[g])
			else $error("alarm condition dropped without a sample");
		low_set_a: assert property (@(posedge pclk) disable iff (!presetn)
			eval_reg && enabled[g] && !config_mode_reg
			&& cfg_reg[g].type_select == PAU_TYPE_LOW && below_thr[g] |=> cond_reg[g])
			else $error("low alarm condition not set");
		mask_block_a: assert property (@(posedge pclk) disable iff (!presetn)
			cfg_reg[g].type_select == PAU_TYPE_LOW_MASKED && mask_reg[g] && !cond_reg[g]
			|=> !cond_reg[g])
			else $error("masked alarm activated");
		restore_arm_a: assert property (@(posedge pclk) disable iff (!presetn)
			mask_restore_command |=> mask_reg[g])
			else $error("mask not re-armed");
		auto_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
			cfg_reg[g].reset_mode != PAU_RESET_LATCHING && !cond_reg[g]
			&& $stable(cfg_reg[g]) |=> !alarm_reg[g])
			else $error("auto alarm stayed active");
		latch_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
			alarm_reg[g] && cfg_reg[g].reset_mode == PAU_RESET_LATCHING && !ack_sync_reg
			&& enabled[g] && !config_mode_reg && $stable(cfg_reg[g]) |=> alarm_reg[g])
			else $error("latched alarm released without acknowledge");
		ack_ignore_a: assert property (@(posedge pclk) disable iff (!presetn)
			cond_reg[g] && enabled[g] && !config_mode_reg ##1 enabled[g] && !config_mode_reg
			|-> alarm_reg[g])
			else $error("alarm cleared while condition present");
		relay_pol_a: assert property (@(posedge pclk) disable iff (!presetn)
			$past(cfg_reg[g].relay_polarity) != PAU_POL_NONFAILSAFE && $past(alarm_reg[g])
			&& !$past(config_mode_reg) |-> !relay_reg[g])
			else $error("failsafe relay energised in alarm");
		config_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
			config_mode_reg ##1 config_mode_reg |-> !alarm_reg[g])
			else $error("alarm shown in configuration mode");
		latch_ack_c: cover property (@(posedge pclk) disable iff (!presetn)
			alarm_reg[g] && !cond_reg[g] && ack_sync_reg ##1 !alarm_reg[g]);
		mask_lift_c: cover property (@(posedge pclk) disable iff (!presetn)
			mask_reg[g] ##1 !mask_reg[g]);
		nonfailsafe_c: cover property (@(posedge pclk) disable iff (!presetn)
			relay_reg[g] && alarm_reg[g]);
	end
endmodule : pau_alarm_unit

// ===== verification/pau_relay_model.sv
// Field side model: three alarm relay coils and the acknowledge pushbutton contact.
module pau_relay_model import pau_pkg::*; (
	// Coil drives from the alarm unit.
	input wire logic [PAU_NUM_ALARMS-1:0] relay_drive,
	// Operator pushbutton, high while held down.
	input wire logic button_pressed,
	// Contact to the unit, pulled up while open.
	output logic ack_contact_n,
	// Coil state seen by the external circuitry.
	output logic [PAU_NUM_ALARMS-1:0] coil_energised
);
	timeunit 1ns;
	timeprecision 1ps;

	////////////////////////////////////////////////////////////////////////////////

	// A closed contact pulls the line low, an open one leaves the pull-up.
	assign ack_contact_n = button_pressed ? 1'b0 : 1'b1;

	// The coil simply follows its drive; polarity is the unit's business.
	assign coil_energised = relay_drive;
endmodule : pau_relay_model

// ===== verification/pau_alarm_unit_test.sv
// Self-checking testbench of the three-channel process alarm unit.
module pau_alarm_unit_test import pau_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;

	////////////////////////////////////////////////////////////////////////////////

	// Clock, reset and APB signals.
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	// Measurement path and field side.
	logic sample_valid = 1'b0;
	logic [15:0] primary_value = 16'h0000;
	logic [15:0] secondary_value = 16'h0000;
	logic button_pressed = 1'b0;
	logic ack_contact_n;
	logic [2:0] alarm_active;
	logic [2:0] relay_drive;
	logic [2:0] coil_energised;
	// Result counters.
	int n_errors = 0;
	int checks = 0;
	logic [31:0] rd;
	logic err;

	// The clock toggles every half period of 10 ns.
	always #5 pclk = ~pclk;

	// Device under test.
	pau_alarm_unit i_pau_alarm_unit (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .sample_valid(sample_valid),
		.primary_value(primary_value), .secondary_value(secondary_value),
		.ack_contact_n(ack_contact_n), .alarm_active(alarm_active),
		.relay_drive(relay_drive));

	// Relays and pushbutton.
	pau_relay_model i_pau_relay_model (.relay_drive(relay_drive),
		.button_pressed(button_pressed), .ack_contact_n(ack_contact_n),
		.coil_energised(coil_energised));

	////////////////////////////////////////////////////////////////////////////////

	// Compares one value and counts it.
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	// Prints the counts and the verdict, then ends the run.
	task automatic report_and_stop();
		$display("checks %0d n_errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : report_and_stop

	// One APB transfer; waits for pready and takes data at that edge.
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Only the watchdog ends a wait that never sees pready.
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// Holds reset low for two cycles.
	task automatic do_reset();
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
	endtask : do_reset

	// Presents one sample and waits until relays have settled.
	task automatic smp(input logic [15:0] p, input logic [15:0] s);
		@(posedge pclk);
		primary_value <= p;
		secondary_value <= s;
		sample_valid <= 1'b1;
		@(posedge pclk);
		sample_valid <= 1'b0;
		repeat (6) @(posedge pclk);
	endtask : smp

	// Writes the per-alarm registers: configuration, threshold, hysteresis.
	task automatic setup_alarm(input int n, input logic [31:0] c, input logic [31:0] t);
		apb(1'b1, 12'h010 + 12'(n * 16), c);
		apb(1'b1, 12'h014 + 12'(n * 16), t);
		apb(1'b1, 12'h018 + 12'(n * 16), 32'h0000001E);
	endtask : setup_alarm

	////////////////////////////////////////////////////////////////////////////////

	// Reset values, clamps, filter codes and two unmapped places.
	task automatic t_registers();
		chk("relay after reset", relay_drive, 3'h7);
		apb(1'b0, 12'h004, 32'h0);
		chk("status reset", rd, 32'h000001F8);
		apb(1'b0, 12'h010, 32'h0);
		chk("cfg reset", rd, 32'h00000040);
		apb(1'b1, 12'h014, 32'h0000FFFF);
		apb(1'b0, 12'h014, 32'h0);
		chk("thr clamp", rd, 32'h00000CE4);
		apb(1'b1, 12'h018, 32'h00000000);
		apb(1'b0, 12'h018, 32'h0);
		chk("hys floor", rd, 32'h00000003);
		apb(1'b1, 12'h018, 32'h000003E8);
		apb(1'b0, 12'h018, 32'h0);
		chk("hys ceiling", rd, 32'h0000012C);
		for (int i = 0; i < 7; i++) begin
			apb(1'b1, 12'h020, 32'(i << 6));
			apb(1'b0, 12'h020, 32'h0);
			chk("filter code", rd, 32'(i << 6));
		end
		apb(1'b0, 12'h040, 32'h0);
		chk("unmapped err", {31'h0, err}, 32'h1);
		apb(1'b0, 12'h050, 32'h0);
		chk("alias err", {31'h0, err}, 32'h1);
	endtask : t_registers

	// High alarm on primary, failsafe, with hysteresis and a disabled source.
	task automatic t_high();
		setup_alarm(0, 32'h00000001, 32'h000007D0);
		smp(16'h07D0, 16'h03E8);
		chk("high at thr", alarm_active, 3'h0);
		smp(16'h07D1, 16'h03E8);
		chk("high set", alarm_active, 3'h1);
		chk("failsafe off", coil_energised, 3'h6);
		apb(1'b0, 12'h01C, 32'h0);
		chk("filtered", rd, 32'h000007D1);
		smp(16'h07B7, 16'h03E8);
		chk("high hold", alarm_active, 3'h1);
		smp(16'h07B1, 16'h03E8);
		chk("high clear", alarm_active, 3'h0);
		apb(1'b1, 12'h010, 32'h00000000);
		smp(16'h0FFF, 16'h03E8);
		chk("source off", alarm_active, 3'h0);
	endtask : t_high

	// Low alarm on secondary, non-failsafe.
	task automatic t_low();
		setup_alarm(1, 32'h00000026, 32'h000002BC);
		chk("nonfs idle", coil_energised, 3'h5);
		smp(16'h03E8, 16'h02BB);
		chk("low set", alarm_active, 3'h2);
		chk("nonfs alarm", coil_energised, 3'h7);
		smp(16'h03E8, 16'h02D9);
		chk("low hold", alarm_active, 3'h2);
		smp(16'h03E8, 16'h02DB);
		chk("low clear", alarm_active, 3'h0);
		apb(1'b1, 12'h020, 32'h00000000);
	endtask : t_low

	// Start-up mask on alarm 3, its lifting and its restore.
	task automatic t_mask();
		setup_alarm(2, 32'h00000009, 32'h000002BC);
		smp(16'h0064, 16'h03E8);
		chk("masked", alarm_active, 3'h0);
		smp(16'h0320, 16'h03E8);
		smp(16'h0258, 16'h03E8);
		chk("unmasked set", alarm_active, 3'h4);
		smp(16'h0320, 16'h03E8);
		chk("auto clear", alarm_active, 3'h0);
		apb(1'b1, 12'h000, 32'h00000002);
		repeat (2) @(posedge pclk);
		apb(1'b0, 12'h004, 32'h0);
		chk("mask rearmed", rd[5], 1'b1);
		smp(16'h0258, 16'h03E8);
		chk("masked again", alarm_active, 3'h0);
		apb(1'b1, 12'h030, 32'h00000000);
	endtask : t_mask

	// Latching alarm: early acknowledge ignored, late one clears.
	task automatic t_latch();
		setup_alarm(0, 32'h00000011, 32'h000007D0);
		smp(16'h0834, 16'h03E8);
		chk("latch set", alarm_active, 3'h1);
		@(posedge pclk);
		button_pressed <= 1'b1;
		repeat (6) @(posedge pclk);
		apb(1'b0, 12'h004, 32'h0);
		chk("ack seen", rd[9], 1'b1);
		chk("early ack", alarm_active, 3'h1);
		button_pressed <= 1'b0;
		smp(16'h03E8, 16'h03E8);
		chk("latch hold", alarm_active, 3'h1);
		@(posedge pclk);
		button_pressed <= 1'b1;
		repeat (6) @(posedge pclk);
		button_pressed <= 1'b0;
		chk("latch clear", alarm_active, 3'h0);
		chk("relay back", coil_energised, 3'h7);
	endtask : t_latch

	// Configuration mode blanks alarms; a reset forgets them.
	task automatic t_cfg_reset();
		apb(1'b1, 12'h010, 32'h00000001);
		smp(16'h0834, 16'h03E8);
		chk("alarm before", alarm_active, 3'h1);
		apb(1'b1, 12'h000, 32'h00000001);
		repeat (4) @(posedge pclk);
		chk("cfg mode alarm", alarm_active, 3'h0);
		chk("cfg mode relay", coil_energised, 3'h7);
		apb(1'b1, 12'h000, 32'h00000000);
		smp(16'h0834, 16'h03E8);
		chk("alarm again", alarm_active, 3'h1);
		do_reset();
		@(posedge pclk);
		chk("reset alarm", alarm_active, 3'h0);
		chk("reset relay", relay_drive, 3'h7);
	endtask : t_cfg_reset

	////////////////////////////////////////////////////////////////////////////////

	// Main sequence.
	initial begin
		do_reset();
		t_registers();
		t_high();
		t_low();
		t_mask();
		t_latch();
		t_cfg_reset();
		report_and_stop();
	end

	// Watchdog well beyond the few hundred cycles the tests need.
	initial begin
		#200000;
		n_errors++;
		report_and_stop();
	end
endmodule : pau_alarm_unit_test
